// ==== rtl/adc_channel_cal_config_regs.sv ====
// APB register slice for channel 3 input select and calibration coefficients
// Notes on behaviour
// - Input select 00 routes the channel pins, 01 shorts the inputs, 10 and 11 apply +/- dc test.
// - The 24-bit signed offset keeps bits 23:8 in its high register and 7:0 in low bits 15:8.
// - The 24-bit unsigned gain spans 0 to just under 2.0 with bits 23:8 in its high register.
// - Channel 2 gain bits 7:0 sit in bits 15:8 of its low register, whose low byte reads zero.
// - The channel 3 gain high register reads 8000h after reset.
// - The channel 3 input configuration reads 0000h after reset, selecting the pins.
module adc_channel_cal_config_regs
    import adc_cal_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Channel 3 input routing, one-hot
    output logic ch3RouteInputs,
    output logic ch3ShortInputs,
    output logic ch3TestPos,
    output logic ch3TestNeg,
    // Joined channel 3 coefficients and the channel 2 gain low byte
    output logic [COEF_W-1:0] ch3OffsetCoef,
    output logic [COEF_W-1:0] ch3GainCoef,
    output logic [LOW_W-1:0] ch2GainCoefLow,
    // Channel 3 conversion results
    input wire logic [COEF_W-1:0] sampleIn,
    input wire logic sampleValid,
    output logic [COEF_W-1:0] correctedSample,
    output logic correctedValid
);

    // Word-aligned address inside the map
    function automatic logic regValid(input logic [ADDR_W-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx = addr[ADDR_W-1:2];
        regValid = (addr[1:0] == 2'h0) &&
                   ((idx == IDX_CH2_GAIN_CAL_LOW) ||
                    (idx == IDX_CH3_INPUT_CONFIG) ||
                    (idx == IDX_CH3_OFFSET_CAL_HIGH) ||
                    (idx == IDX_CH3_OFFSET_CAL_LOW) ||
                    (idx == IDX_CH3_GAIN_CAL_HIGH) ||
                    (idx == IDX_CH3_GAIN_CAL_LOW));
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [REG_W-1:0] mergeBytes(
        input logic [REG_W-1:0] old,
        input logic [DATA_W-1:0] wdata,
        input logic [3:0] strb
    );
        mergeBytes = old;
        if (strb[0])
        begin
            mergeBytes[7:0] = wdata[7:0];
        end
        if (strb[1])
        begin
            mergeBytes[15:8] = wdata[15:8];
        end
    endfunction

    // Register storage
    logic [CFG_SEL_W-1:0] ch3InputSelect;
    logic cfgSpare;
    logic [CFG_HIGH_W-1:0] cfgHigh;
    logic [REG_W-1:0] cfgWord;
    logic [REG_W-1:0] cfgMerged;
    logic [REG_W-1:0] wordMerged;
    logic [CFG_SEL_W-1:0] next_ch3InputSelect;
    logic next_cfgSpare;
    logic [CFG_HIGH_W-1:0] next_cfgHigh;
    logic [COEF_W-1:0] next_ch3OffsetCoef;
    logic [COEF_W-1:0] next_ch3GainCoef;
    logic [LOW_W-1:0] next_ch2GainCoefLow;
    logic next_ch3RouteInputs;
    logic next_ch3ShortInputs;
    logic next_ch3TestPos;
    logic next_ch3TestNeg;

    // Bus state
    logic [DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [REG_W-1:0] readWord;
    logic setupPhase;
    logic writeTaken;
    logic [IDX_W-1:0] accessIdx;

    assign accessIdx = paddr[ADDR_W-1:2];
    assign setupPhase = psel && !penable;
    // A write lands only at the completing edge of a mapped access
    assign writeTaken = psel && penable && pready && pwrite && !pslverr;

    // Readback image of every register
    always_comb
    begin
        cfgWord = '0;
        cfgWord[CFG_SEL_LSB +: CFG_SEL_W] = ch3InputSelect;
        cfgWord[CFG_SPARE_BIT] = cfgSpare;
        cfgWord[CFG_HIGH_LSB +: CFG_HIGH_W] = cfgHigh;
        readWord = '0;
        case (accessIdx)
            IDX_CH3_INPUT_CONFIG:
            begin
                // Bits 5:3 are never stored and read zero
                readWord = cfgWord;
            end
            IDX_CH3_OFFSET_CAL_HIGH:
            begin
                readWord = ch3OffsetCoef[COEF_W-1:COEF_HIGH_LSB];
            end
            IDX_CH3_OFFSET_CAL_LOW:
            begin
                readWord[LOW_FIELD_LSB +: LOW_W] = ch3OffsetCoef[LOW_W-1:0];
            end
            IDX_CH3_GAIN_CAL_HIGH:
            begin
                readWord = ch3GainCoef[COEF_W-1:COEF_HIGH_LSB];
            end
            IDX_CH3_GAIN_CAL_LOW:
            begin
                readWord[LOW_FIELD_LSB +: LOW_W] = ch3GainCoef[LOW_W-1:0];
            end
            IDX_CH2_GAIN_CAL_LOW:
            begin
                // Low byte stays zero
                readWord[LOW_FIELD_LSB +: LOW_W] = ch2GainCoefLow;
            end
            default:
            begin
                readWord = '0;
            end
        endcase
    end

    // APB answer: pready rises the cycle after setup, so each access is two cycles
    always_comb
    begin
        next_pready = setupPhase;
        next_pslverr = setupPhase && !regValid(paddr);
        next_prdata = '0;
        if (setupPhase && !pwrite && regValid(paddr))
        begin
            next_prdata = DATA_W'(readWord);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Register writes
    always_comb
    begin
        next_ch3InputSelect = ch3InputSelect;
        next_cfgSpare = cfgSpare;
        next_cfgHigh = cfgHigh;
        next_ch3OffsetCoef = ch3OffsetCoef;
        next_ch3GainCoef = ch3GainCoef;
        next_ch2GainCoefLow = ch2GainCoefLow;
        cfgMerged = mergeBytes(cfgWord, pwdata, pstrb) & CFG_WRITE_MASK;
        wordMerged = mergeBytes(readWord, pwdata, pstrb);
        if (writeTaken)
        begin
            case (accessIdx)
                IDX_CH3_INPUT_CONFIG:
                begin
                    next_ch3InputSelect = cfgMerged[CFG_SEL_LSB +: CFG_SEL_W];
                    next_cfgSpare = cfgMerged[CFG_SPARE_BIT];
                    next_cfgHigh = cfgMerged[CFG_HIGH_LSB +: CFG_HIGH_W];
                end
                IDX_CH3_OFFSET_CAL_HIGH:
                begin
                    next_ch3OffsetCoef[COEF_W-1:COEF_HIGH_LSB] = wordMerged;
                end
                IDX_CH3_OFFSET_CAL_LOW:
                begin
                    // Only the upper byte is writable
                    next_ch3OffsetCoef[LOW_W-1:0] =
                        wordMerged[LOW_FIELD_LSB +: LOW_W];
                end
                IDX_CH3_GAIN_CAL_HIGH:
                begin
                    next_ch3GainCoef[COEF_W-1:COEF_HIGH_LSB] = wordMerged;
                end
                IDX_CH3_GAIN_CAL_LOW:
                begin
                    next_ch3GainCoef[LOW_W-1:0] = wordMerged[LOW_FIELD_LSB +: LOW_W];
                end
                IDX_CH2_GAIN_CAL_LOW:
                begin
                    next_ch2GainCoefLow = wordMerged[LOW_FIELD_LSB +: LOW_W];
                end
                default:
                begin
                    next_ch2GainCoefLow = ch2GainCoefLow;
                end
            endcase
        end
    end

    // Input routing follows the select field in the same cycle as the register
    always_comb
    begin
        next_ch3RouteInputs = 1'b0;
        next_ch3ShortInputs = 1'b0;
        next_ch3TestPos = 1'b0;
        next_ch3TestNeg = 1'b0;
        case (next_ch3InputSelect)
            SEL_PINS:
            begin
                next_ch3RouteInputs = 1'b1;
            end
            SEL_SHORTED:
            begin
                next_ch3ShortInputs = 1'b1;
            end
            SEL_TEST_POS:
            begin
                next_ch3TestPos = 1'b1;
            end
            SEL_TEST_NEG:
            begin
                next_ch3TestNeg = 1'b1;
            end
            default:
            begin
                next_ch3RouteInputs = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            // Reset image selects the pins
            ch3InputSelect <= RST_CH3_INPUT_CONFIG[CFG_SEL_LSB +: CFG_SEL_W];
            cfgSpare <= RST_CH3_INPUT_CONFIG[CFG_SPARE_BIT];
            cfgHigh <= RST_CH3_INPUT_CONFIG[CFG_HIGH_LSB +: CFG_HIGH_W];
            ch3OffsetCoef <= {RST_CH3_OFFSET_CAL_HIGH, RST_CH3_OFFSET_CAL_LOW};
            // Gain starts at unity, only the top bit set
            ch3GainCoef <= {RST_CH3_GAIN_CAL_HIGH, RST_CH3_GAIN_CAL_LOW};
            ch2GainCoefLow <= RST_CH2_GAIN_CAL_LOW;
            ch3RouteInputs <= 1'b1;
            ch3ShortInputs <= 1'b0;
            ch3TestPos <= 1'b0;
            ch3TestNeg <= 1'b0;
        end
        else
        begin
            ch3InputSelect <= next_ch3InputSelect;
            cfgSpare <= next_cfgSpare;
            cfgHigh <= next_cfgHigh;
            ch3OffsetCoef <= next_ch3OffsetCoef;
            ch3GainCoef <= next_ch3GainCoef;
            ch2GainCoefLow <= next_ch2GainCoefLow;
            ch3RouteInputs <= next_ch3RouteInputs;
            ch3ShortInputs <= next_ch3ShortInputs;
            ch3TestPos <= next_ch3TestPos;
            ch3TestNeg <= next_ch3TestNeg;
        end
    end

    // Correction always uses the joined 24-bit coefficients
    cal_correct correct_ch3 (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .offsetCoef(ch3OffsetCoef),
        .gainCoef(ch3GainCoef),
        .sampleIn(sampleIn),
        .sampleValid(sampleValid),
        .correctedSample(correctedSample),
        .correctedValid(correctedValid)
    );

endmodule

// ==== rtl/cal_correct.sv ====
// Offset and gain correction of one conversion result
module cal_correct
    import adc_cal_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Coefficients
    input wire logic [COEF_W-1:0] offsetCoef,
    input wire logic [COEF_W-1:0] gainCoef,
    // Raw result
    input wire logic [COEF_W-1:0] sampleIn,
    input wire logic sampleValid,
    // Corrected result
    output logic [COEF_W-1:0] correctedSample,
    output logic correctedValid
);

    localparam int DIFF_W = COEF_W + 1;
    localparam int PROD_W = 2 * DIFF_W;
    localparam logic signed [PROD_W-1:0] MAX_POS = PROD_W'(24'sh7f_ffff);
    localparam logic signed [PROD_W-1:0] MAX_NEG = -PROD_W'(25'sh080_0000);

    logic signed [DIFF_W-1:0] diff;
    logic signed [DIFF_W-1:0] gainSigned;
    logic signed [PROD_W-1:0] product;
    logic signed [PROD_W-1:0] scaled;
    logic [COEF_W-1:0] next_correctedSample;
    logic next_correctedValid;

    always_comb
    begin
        // Offset is subtracted first, then the unsigned gain scales the result
        diff = DIFF_W'($signed(sampleIn)) - DIFF_W'($signed(offsetCoef));
        gainSigned = $signed({1'b0, gainCoef});
        product = PROD_W'(diff) * PROD_W'(gainSigned);
        scaled = product >>> GAIN_FRAC_W;
        next_correctedValid = sampleValid;
        next_correctedSample = correctedSample;
        if (sampleValid)
        begin
            if (scaled > MAX_POS)
            begin
                next_correctedSample = MAX_POS[COEF_W-1:0];
            end
            else if (scaled < MAX_NEG)
            begin
                next_correctedSample = MAX_NEG[COEF_W-1:0];
            end
            else
            begin
                next_correctedSample = scaled[COEF_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            correctedSample <= '0;
            correctedValid <= 1'b0;
        end
        else
        begin
            correctedSample <= next_correctedSample;
            correctedValid <= next_correctedValid;
        end
    end

endmodule

// ==== shared/adc_cal_pkg.sv ====
// Register map, field layout and reset values of the channel calibration slice
package adc_cal_pkg;

    // APB widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int IDX_W = 10;
    localparam int COEF_W = 24;
    localparam int LOW_W = 8;

    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CH2_GAIN_CAL_LOW = 10'h017;
    localparam logic [IDX_W-1:0] IDX_CH3_INPUT_CONFIG = 10'h018;
    localparam logic [IDX_W-1:0] IDX_CH3_OFFSET_CAL_HIGH = 10'h019;
    localparam logic [IDX_W-1:0] IDX_CH3_OFFSET_CAL_LOW = 10'h01a;
    localparam logic [IDX_W-1:0] IDX_CH3_GAIN_CAL_HIGH = 10'h01b;
    localparam logic [IDX_W-1:0] IDX_CH3_GAIN_CAL_LOW = 10'h01c;

    // Reset values
    localparam logic [REG_W-1:0] RST_CH3_INPUT_CONFIG = 16'h0000;
    localparam logic [REG_W-1:0] RST_CH3_OFFSET_CAL_HIGH = 16'h0000;
    localparam logic [LOW_W-1:0] RST_CH3_OFFSET_CAL_LOW = 8'h00;
    localparam logic [REG_W-1:0] RST_CH3_GAIN_CAL_HIGH = 16'h8000;
    localparam logic [LOW_W-1:0] RST_CH3_GAIN_CAL_LOW = 8'h00;
    localparam logic [LOW_W-1:0] RST_CH2_GAIN_CAL_LOW = 8'h00;

    // Input configuration fields
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_SEL_W = 2;
    localparam int CFG_SPARE_BIT = 2;
    localparam int CFG_HIGH_LSB = 6;
    localparam int CFG_HIGH_W = 10;
    // Bits 5:3 are read-only zero
    localparam logic [REG_W-1:0] CFG_WRITE_MASK = 16'hffc7;

    // Coefficient split: high word holds bits 23:8, low byte sits in 15:8
    localparam int COEF_HIGH_LSB = 8;
    localparam int LOW_FIELD_LSB = 8;

    // Input select codes
    localparam logic [CFG_SEL_W-1:0] SEL_PINS = 2'h0;
    localparam logic [CFG_SEL_W-1:0] SEL_SHORTED = 2'h1;
    localparam logic [CFG_SEL_W-1:0] SEL_TEST_POS = 2'h2;
    localparam logic [CFG_SEL_W-1:0] SEL_TEST_NEG = 2'h3;

    // Unity gain is the coefficient 800000h; fraction bits of the gain
    localparam int GAIN_FRAC_W = 23;

endpackage

// ==== tb/adc_cal_props.sv ====
// Checker for the channel calibration register slice
module adc_cal_props
    import adc_cal_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    // Routing, coefficients, samples
    input wire logic ch3RouteInputs,
    input wire logic ch3ShortInputs,
    input wire logic ch3TestPos,
    input wire logic ch3TestNeg,
    input wire logic [COEF_W-1:0] ch3OffsetCoef,
    input wire logic [COEF_W-1:0] ch3GainCoef,
    input wire logic sampleValid,
    input wire logic correctedValid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_wr(logic [IDX_W-1:0] i);
        psel && penable && pready && pwrite && paddr == {i, 2'h0} && pstrb[1:0] == 2'h3;
    endsequence

    chk_route_decode: assert property (s_wr(IDX_CH3_INPUT_CONFIG) |=>
        {ch3TestNeg, ch3TestPos, ch3ShortInputs, ch3RouteInputs} == 4'h1 << $past(pwdata[1:0]))
        else $error("route decode wrong");
    chk_offset_high: assert property (s_wr(IDX_CH3_OFFSET_CAL_HIGH) |=>
        ch3OffsetCoef[23:8] == $past(pwdata[15:0]) && $stable(ch3OffsetCoef[7:0]))
        else $error("offset high word misplaced");
    chk_offset_low: assert property (s_wr(IDX_CH3_OFFSET_CAL_LOW) |=>
        ch3OffsetCoef[7:0] == $past(pwdata[15:8]) && $stable(ch3OffsetCoef[23:8]))
        else $error("offset low byte misplaced");
    chk_gain_high: assert property (s_wr(IDX_CH3_GAIN_CAL_HIGH) |=>
        ch3GainCoef[23:8] == $past(pwdata[15:0]))
        else $error("gain high word misplaced");
    chk_low_zero: assert property (psel && penable && pready && !pwrite &&
        (paddr == {IDX_CH2_GAIN_CAL_LOW, 2'h0} || paddr == {IDX_CH3_GAIN_CAL_LOW, 2'h0}
        || paddr == {IDX_CH3_OFFSET_CAL_LOW, 2'h0}) |-> prdata[7:0] == 8'h00)
        else $error("reserved low byte not zero");
    chk_gain_reset: assert property ($rose(rstn) |-> ch3GainCoef == 24'h80_0000)
        else $error("gain reset value wrong");
    chk_route_reset: assert property ($rose(rstn) |->
        (ch3RouteInputs && !(ch3ShortInputs || ch3TestPos || ch3TestNeg)) [*2])
        else $error("routing after reset wrong");
    chk_sample_answer: assert property (sampleValid |=> correctedValid)
        else $error("corrected result missing");
endmodule

bind adc_channel_cal_config_regs adc_cal_props u_props (
    .clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .ch3RouteInputs, .ch3ShortInputs, .ch3TestPos, .ch3TestNeg, .ch3OffsetCoef,
    .ch3GainCoef, .sampleValid, .correctedValid
);

// ==== tb/tb.sv ====
// Self-checking bench for the channel calibration register slice
module tb
    import adc_cal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'h0;
    logic [COEF_W-1:0] sampleIn = '0;
    logic sampleValid = 1'h0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, ch3RouteInputs, ch3ShortInputs, ch3TestPos, ch3TestNeg;
    logic correctedValid;
    logic [COEF_W-1:0] ch3OffsetCoef, ch3GainCoef, correctedSample;
    logic [LOW_W-1:0] ch2GainCoefLow;
    logic [32:0] busQ[$];
    logic [23:0] smpQ[$];
    logic [23:0] off, gain, s;
    logic [15:0] d;
    int n_fail = 0;
    int total_checks = 0;
    wire logic [3:0] routeBits = {ch3TestNeg, ch3TestPos, ch3ShortInputs, ch3RouteInputs};

    always #4 clk_sys = ~clk_sys;

    adc_channel_cal_config_regs DUT (
        .clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .ch3RouteInputs, .ch3ShortInputs, .ch3TestPos, .ch3TestNeg, .ch3OffsetCoef,
        .ch3GainCoef, .ch2GainCoefLow, .sampleIn, .sampleValid, .correctedSample, .correctedValid
    );

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [ADDR_W-1:0] ad(input logic [IDX_W-1:0] i);
        return {i, 2'h0};
    endfunction

    // Subtract offset, scale by gain with 23 fraction bits, saturate to 24 bits
    function automatic logic [23:0] corr(input logic [23:0] x);
        longint v;
        v = (longint'($signed(x)) - longint'($signed(off))) * longint'({40'h0, gain});
        v = v >>> 23;
        if (v > 64'sh7f_ffff)
            return 24'h7f_ffff;
        if (v < -64'sh80_0000)
            return 24'h80_0000;
        return v[23:0];
    endfunction

    // Leaves psel up so that a next setup can follow at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] dt,
                       input logic [3:0] st, input logic [32:0] exp);
        busQ.push_back(exp);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, dt};
        pstrb <= st;
        @(posedge clk_sys);
        penable <= 1'h1;
        // Request stands until the edge at which pready is sampled high
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'h1);
    endtask

    task automatic rd(input logic [IDX_W-1:0] i, input logic [15:0] e);
        apb(1'h0, ad(i), 16'h0000, 4'h0, {17'h0_0000, e});
    endtask

    task automatic wr(input logic [IDX_W-1:0] i, input logic [15:0] dt, input logic [3:0] st);
        apb(1'h1, ad(i), dt, st, 33'h0);
    endtask

    task automatic idle();
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask

    // Results are taken at the completing rising edge
    always @(posedge clk_sys)
    begin
        if (psel && penable && pready === 1'h1)
            check("apb", {pslverr, prdata}, busQ.pop_front());
        if (correctedValid === 1'h1)
            check("sample", correctedSample, smpQ.pop_front());
    end

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        stop_test();
    end

    initial
    begin
        void'($urandom(32'h8bd2_4306));
        repeat (4) @(posedge clk_sys);
        rstn <= 1'h1;
        @(posedge clk_sys);
        check("gain", ch3GainCoef, 24'h80_0000);
        check("route", routeBits, 4'h1);
        rd(IDX_CH3_INPUT_CONFIG, 16'h0000);
        rd(IDX_CH3_OFFSET_CAL_HIGH, 16'h0000);
        rd(IDX_CH3_OFFSET_CAL_LOW, 16'h0000);
        rd(IDX_CH3_GAIN_CAL_HIGH, 16'h8000);
        rd(IDX_CH3_GAIN_CAL_LOW, 16'h0000);
        rd(IDX_CH2_GAIN_CAL_LOW, 16'h0000);
        idle();
        for (int c = 0; c < 4; c++)
        begin
            d = 16'($urandom());
            d[1:0] = 2'(c);
            wr(IDX_CH3_INPUT_CONFIG, d, 4'h3);
            rd(IDX_CH3_INPUT_CONFIG, d & CFG_WRITE_MASK);
            idle();
            check("route", routeBits, 4'h1 << c);
        end
        off = 24'($urandom());
        gain = 24'($urandom());
        wr(IDX_CH3_OFFSET_CAL_HIGH, off[23:8], 4'h3);
        wr(IDX_CH3_OFFSET_CAL_LOW, {off[7:0], 8'($urandom())}, 4'h3);
        // Upper lane only
        wr(IDX_CH3_OFFSET_CAL_HIGH, ~off[23:8], 4'h2);
        off[23:16] = ~off[23:16];
        wr(IDX_CH3_GAIN_CAL_HIGH, gain[23:8], 4'h3);
        wr(IDX_CH3_GAIN_CAL_LOW, {gain[7:0], 8'hff}, 4'h3);
        d = 16'($urandom());
        wr(IDX_CH2_GAIN_CAL_LOW, d, 4'h3);
        rd(IDX_CH3_OFFSET_CAL_LOW, {off[7:0], 8'h00});
        rd(IDX_CH3_GAIN_CAL_LOW, {gain[7:0], 8'h00});
        rd(IDX_CH2_GAIN_CAL_LOW, {d[15:8], 8'h00});
        // Unmapped read and misaligned write are refused
        apb(1'h0, 12'h074, 16'h0000, 4'h0, {1'h1, 32'h0});
        apb(1'h1, ad(IDX_CH3_GAIN_CAL_HIGH) + 12'h2, 16'h0000, 4'h3, {1'h1, 32'h0});
        rd(IDX_CH3_GAIN_CAL_HIGH, gain[23:8]);
        idle();
        check("offset", ch3OffsetCoef, off);
        check("gain", ch3GainCoef, gain);
        check("ch2low", ch2GainCoefLow, d[15:8]);
        for (int i = 0; i < 16; i++)
        begin
            s = 24'($urandom());
            smpQ.push_back(corr(s));
            sampleIn <= s;
            sampleValid <= 1'h1;
            @(posedge clk_sys);
        end
        sampleValid <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'h1;
        @(posedge clk_sys);
        check("gain", ch3GainCoef, 24'h80_0000);
        check("route", routeBits, 4'h1);
        rd(IDX_CH3_INPUT_CONFIG, 16'h0000);
        idle();
        check("pending", busQ.size() + smpQ.size(), 33'h0);
        stop_test();
    end
endmodule
